// *** hdl/eesr_pkg.sv ***
// shared constants and types of the serial eeprom read engine
package eesr_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes and fixed protocol values
	localparam int          ADDR_W      = 13;      // byte address counter width
	localparam int          FIFO_DEPTH  = 8;       // prefetch buffer depth
	localparam int          BYTE_W      = 8;
	localparam logic [3:0]  DEV_TYPE    = 4'ha;    // upper nibble of a device select byte
	localparam logic [7:0]  ERASED_BYTE = 8'hff;   // content of a never written cell
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [3:0]  LAST_TX_BIT = 4'h7;

	////////////////////////////////////////////////////////////////////////
	// protocol states, one-hot
	typedef enum logic [9:0] {
		ST_IDLE    = 10'h001,
		ST_DEVSEL  = 10'h002,
		ST_ACK_DS  = 10'h004,
		ST_ADDR_HI = 10'h008,
		ST_ACK_AH  = 10'h010,
		ST_ADDR_LO = 10'h020,
		ST_ACK_AL  = 10'h040,
		ST_IGNORE  = 10'h080,
		ST_TX      = 10'h100,
		ST_RXACK   = 10'h200
	} eesr_state_t;

	// the two bus wires as sampled together
	typedef struct packed {
		logic scl;
		logic sda;
	} eesr_line_t;

	localparam eesr_line_t LINE_IDLE = '{scl: 1'b1, sda: 1'b1};

endpackage

// *** hdl/eesr_fifo.sv ***
// prefetch fifo between the memory array and the serial shifter
`timescale 1ns/1ps
module eesr_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic         ref_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [PW:0]   count;
	} fifo_state_t;

	fifo_state_t q;
	fifo_state_t next_q;
	logic [W-1:0] store [DEPTH];
	logic         do_push;
	logic         do_pop;

	////////////////////////////////////////////////////////////////////////
	// full and empty come straight from the occupancy count
	assign in_ready_o  = (q.count != (PW+1)'(DEPTH));
	assign out_valid_o = (q.count != '0);
	assign out_data_o  = store[q.rptr];
	assign do_push     = in_valid_i & in_ready_o & ~flush_i;
	assign do_pop      = out_valid_o & out_ready_i & ~flush_i;

	// pointer update; flush drops everything, including a same-cycle push
	always_comb begin
		next_q = q;
		if (flush_i) begin
			next_q = '0;
		end else begin
			if (do_push) begin
				next_q.wptr = (q.wptr == PW'(DEPTH-1)) ? '0 : q.wptr + 1'b1;
			end
			if (do_pop) begin
				next_q.rptr = (q.rptr == PW'(DEPTH-1)) ? '0 : q.rptr + 1'b1;
			end
			next_q.count = q.count + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// storage needs no reset, the count guards every read
	always_ff @(posedge ref_clk_i) begin
		if (do_push) begin
			store[q.wptr] <= in_data_i;
		end
	end

endmodule // eesr_fifo

// *** hdl/eesr_read.sv ***
// serial eeprom slave: device select, address load and sequential read
// Function
// - sequential read starts as current or random
// - master ack continues with next byte
// - address counter increments as each output byte is loaded
// - counter wraps past top address, output continues
// - release sda, sample master ack on clock nine
// - no ack from master returns to standby
// - unwritten memory reads as all ones
// - select byte with read bit one starts output
// - current read returns byte at counter, increments
// - random read loads counter via dummy write first
`timescale 1ns/1ps
module eesr_read #(
	parameter int ADDR_W     = eesr_pkg::ADDR_W,
	parameter int FIFO_DEPTH = eesr_pkg::FIFO_DEPTH
) (
	input  wire logic              ref_clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	input  wire logic [2:0]        chip_en_i,
	input  wire logic              mem_we_i,
	input  wire logic [ADDR_W-1:0] mem_waddr_i,
	input  wire logic [7:0]        mem_wdata_i,
	output logic                   busy_o,
	output logic [ADDR_W-1:0]      addr_o
);
	localparam int DEPTH = 2 ** ADDR_W;

	typedef struct packed {
		eesr_pkg::eesr_state_t st;
		logic [3:0]            bitcnt;
		logic [7:0]            shreg;
		logic [7:0]            hi;
		logic                  rw;
		logic [ADDR_W-1:0]     addr;
		logic [ADDR_W-1:0]     fetch_addr;
		logic                  pend;
		logic                  oe;
		eesr_pkg::eesr_line_t  s1;
		eesr_pkg::eesr_line_t  s2;
		eesr_pkg::eesr_line_t  prev;
		logic [2:0]            ce1;
		logic [2:0]            ce2;
	} core_t;

	core_t        q;
	core_t        next_q;
	// erased at delivery; declared once so only the write port drives it
	logic [7:0]   mem [DEPTH] = '{default: eesr_pkg::ERASED_BYTE};
	logic [7:0]   rd_q;
	logic         flush;
	logic         pop;
	logic         fifo_in_ready;
	logic         fifo_out_valid;
	logic [7:0]   fifo_out_data;
	logic         scl_rise;
	logic         scl_fall;
	logic         bus_start;
	logic         bus_stop;
	logic [15:0]  full_addr;

	////////////////////////////////////////////////////////////////////////
	// memory array; a reset leaves the cells alone

	// backdoor load port; read port runs every cycle at the fetch address
	always_ff @(posedge ref_clk_i) begin
		if (mem_we_i) begin
			mem[mem_waddr_i] <= mem_wdata_i;
		end
		rd_q <= mem[q.fetch_addr];
	end

	////////////////////////////////////////////////////////////////////////
	// prefetch buffer keeps the next bytes ready long before scl asks
	eesr_fifo #(
		.W     (eesr_pkg::BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i   (ref_clk_i),
		.sys_rst_i   (sys_rst_i),
		.flush_i     (flush),
		.in_valid_i  (q.pend),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (rd_q),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////
	// bus events from the second synchroniser stage only
	assign scl_rise  = q.s2.scl & ~q.prev.scl;
	assign scl_fall  = ~q.s2.scl & q.prev.scl;
	assign bus_start = q.s2.scl & q.prev.scl & q.prev.sda & ~q.s2.sda;
	assign bus_stop  = q.s2.scl & q.prev.scl & ~q.prev.sda & q.s2.sda;
	// high byte first, upper bits dropped by the cut
	assign full_addr = {q.hi, q.shreg};

	// next state of the whole engine
	always_comb begin
		next_q      = q;
		next_q.s1   = '{scl: scl_i, sda: sda_i};
		next_q.s2   = q.s1;
		next_q.prev = q.s2;
		next_q.ce1  = chip_en_i;
		next_q.ce2  = q.ce1;
		flush       = 1'b0;
		pop         = 1'b0;

		case (q.st)
			eesr_pkg::ST_DEVSEL, eesr_pkg::ST_ADDR_HI,
			eesr_pkg::ST_ADDR_LO, eesr_pkg::ST_IGNORE: begin
				if (scl_rise) begin
					next_q.shreg  = {q.shreg[6:0], q.s2.sda};
					next_q.bitcnt = q.bitcnt + 4'h1;
				end else if (scl_fall && q.bitcnt == eesr_pkg::BITS_PER_BYTE) begin
					next_q.bitcnt = '0;
					if (q.st == eesr_pkg::ST_DEVSEL) begin
						// compared afresh on every select byte
						if (q.shreg[7:1] == {eesr_pkg::DEV_TYPE, q.ce2}) begin
							next_q.rw = q.shreg[0];
							next_q.oe = 1'b1;
							next_q.st = eesr_pkg::ST_ACK_DS;
						end else begin
							next_q.st = eesr_pkg::ST_IDLE;
						end
					end else if (q.st == eesr_pkg::ST_ADDR_HI) begin
						next_q.hi = q.shreg;
						next_q.oe = 1'b1;
						next_q.st = eesr_pkg::ST_ACK_AH;
					end else if (q.st == eesr_pkg::ST_ADDR_LO) begin
						next_q.addr       = full_addr[ADDR_W-1:0];
						next_q.fetch_addr = full_addr[ADDR_W-1:0];
						flush             = 1'b1;
						next_q.oe         = 1'b1;
						next_q.st         = eesr_pkg::ST_ACK_AL;
					end
					// data bytes of a write are not taken by this engine
				end
			end
			eesr_pkg::ST_ACK_DS, eesr_pkg::ST_ACK_AH, eesr_pkg::ST_ACK_AL: begin
				if (scl_fall) begin
					next_q.oe = 1'b0;
					if (q.st == eesr_pkg::ST_ACK_AH) begin
						next_q.st = eesr_pkg::ST_ADDR_LO;
					end else if (q.st == eesr_pkg::ST_ACK_AL) begin
						next_q.st = eesr_pkg::ST_IGNORE;
					end else if (!q.rw) begin
						next_q.st = eesr_pkg::ST_ADDR_HI;
					end else begin
						// read select acknowledged, first byte out
						// byte at the counter, then counter steps
						// same entry for single and sequential reads
						pop         = 1'b1;
						next_q.shreg  = fifo_out_data;
						next_q.oe     = ~fifo_out_data[7];
						next_q.bitcnt = '0;
						next_q.addr   = q.addr + 1'b1;
						next_q.st     = eesr_pkg::ST_TX;
					end
				end
			end
			eesr_pkg::ST_TX: begin
				if (scl_fall) begin
					next_q.bitcnt = q.bitcnt + 4'h1;
					if (q.bitcnt == eesr_pkg::LAST_TX_BIT) begin
						// let go of sda for the ack clock
						next_q.oe = 1'b0;
						next_q.st = eesr_pkg::ST_RXACK;
					end else begin
						// msb first, changed only after scl falls
						next_q.shreg = {q.shreg[6:0], 1'b0};
						next_q.oe    = ~q.shreg[6];
					end
				end
			end
			eesr_pkg::ST_RXACK: begin
				// ack sampled on the rising edge of clock nine
				if (scl_rise && q.s2.sda) begin
					// master ends the stream this way
					next_q.st = eesr_pkg::ST_IDLE;
				end else if (scl_fall) begin
					// acked, next byte with no new command
					// counter wraps naturally at its width
					pop           = 1'b1;
					next_q.shreg  = fifo_out_data;
					next_q.oe     = ~fifo_out_data[7];
					next_q.bitcnt = '0;
					next_q.addr   = q.addr + 1'b1;
					next_q.st     = eesr_pkg::ST_TX;
				end
			end
			eesr_pkg::ST_IDLE: begin
				next_q.oe = 1'b0;
			end
			default: begin
				next_q.st = eesr_pkg::ST_IDLE;
				next_q.oe = 1'b0;
			end
		endcase

		// start and stop override any byte in progress
		if (bus_start) begin
			// restart prefetch at the counter in case the array was reloaded
			flush             = 1'b1;
			next_q.fetch_addr = q.addr;
			next_q.bitcnt     = '0;
			next_q.oe         = 1'b0;
			next_q.st         = eesr_pkg::ST_DEVSEL;
		end else if (bus_stop) begin
			next_q.oe = 1'b0;
			next_q.st = eesr_pkg::ST_IDLE;
		end

		// one read in flight at most, so a granted fetch always finds room
		next_q.pend = 1'b0;
		if (flush) begin
			next_q.pend = 1'b0;
		end else if (fifo_in_ready && !q.pend) begin
			next_q.pend       = 1'b1;
			next_q.fetch_addr = q.fetch_addr + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register; the bus lines reset to their idle high level
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			q      <= '0;
			q.st   <= eesr_pkg::ST_IDLE;
			q.s1   <= eesr_pkg::LINE_IDLE;
			q.s2   <= eesr_pkg::LINE_IDLE;
			q.prev <= eesr_pkg::LINE_IDLE;
		end else begin
			q <= next_q;
		end
	end

	// open drain: only ever pulls low
	assign sda_o    = 1'b0;
	assign sda_oe_o = q.oe;
	assign busy_o   = (q.st != eesr_pkg::ST_IDLE);
	assign addr_o   = q.addr;

endmodule // eesr_read

// *** testbench/eesr_read_monitor.sv ***
// assertion checker on the read engine ports
`timescale 1ns/1ps
module eesr_read_monitor #(
	parameter int ADDR_W = 13
) (
	input wire logic              ref_clk_i,
	input wire logic              sys_rst_i,
	input wire logic              scl_i,
	input wire logic              sda_i,
	input wire logic              sda_o,
	input wire logic              sda_oe_o,
	input wire logic              busy_o,
	input wire logic [ADDR_W-1:0] addr_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////////////
	// bus timing: sda drive and counter move only in the scl low phase
	property p_bit_stable; $rose(scl_i) |=> $stable(sda_oe_o) [*4]; endproperty
	a_bit_stable: assert property (p_bit_stable) else $error("sda moved in high");
	property p_drive_low; $changed(sda_oe_o) |-> !scl_i; endproperty
	a_drive_low: assert property (p_drive_low) else $error("sda edge with scl high");
	property p_open_drain; sda_o == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda driven high");
	property p_addr_stable; $rose(scl_i) |=> $stable(addr_o) [*4]; endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("counter moved in high");
	////////////////////////////////////////////////////////////////////////
	// transfer framing and counter wrap
	property p_start_busy; $rose(busy_o) |-> scl_i && !sda_i; endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy without start");
	property p_nack_idle; $fell(busy_o) |-> scl_i; endproperty
	a_nack_idle: assert property (p_nack_idle) else $error("idle off ack slot");
	property p_idle_quiet; !busy_o |-> !sda_oe_o; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
	property p_wrap;
		$changed(addr_o) && $past(addr_o) == '1 && $past(busy_o) |-> addr_o == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");
endmodule // eesr_read_monitor

// *** testbench/eesr_master.sv ***
// bus master model: scl generator and open drain data driver
`timescale 1ns/1ps
module eesr_master (
	input  wire logic  ref_clk_i,
	input  wire logic  sda_i,
	output logic       scl_o,
	output logic       sda_low_o,
	output logic [7:0] rd_byte_o,
	output logic       rd_stb_o
);
	// clocks per scl phase; engine needs six, this stays below 400 kHz
	localparam int H = 13;
	// bus idle; called by the bench at time zero so one process drives the lines
	task automatic init();
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		rd_byte_o = 8'h00;
		rd_stb_o = 1'b0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// data set mid low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		wt(6);
		sda_low_o = !b;
		wt(7);
		scl_o = 1'b1;
		wt(6);
		s = sda_i;
		wt(7);
		scl_o = 1'b0;
	endtask
	// start or repeated start, scl left low
	task automatic start();
		sda_low_o = 1'b0;
		if (!scl_o) begin
			wt(H);
			scl_o = 1'b1;
			wt(H);
		end
		sda_low_o = 1'b1;
		wt(H);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		wt(6);
		sda_low_o = 1'b1;
		wt(7);
		scl_o = 1'b1;
		wt(H);
		sda_low_o = 1'b0;
		wt(H);
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
		bit_io(1'b1, ack);
	endtask
	task automatic rd_byte(input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			rd_byte_o[i] = s;
		end
		rd_stb_o = 1'b1;
		bit_io(last, s);
		rd_stb_o = 1'b0;
	endtask
endmodule // eesr_master

// *** testbench/eesr_read_tb_top.sv ***
// testbench top: reset, backdoor loads, current, random and wrapping reads
`timescale 1ns/1ps
module eesr_read_tb_top;
	localparam int AW = eesr_pkg::ADDR_W;
	logic          clk;
	logic          rst;
	logic          scl;
	logic          m_low;
	logic          sda;
	logic          oe;
	logic          busy;
	logic          we;
	logic          stb;
	logic [2:0]    chip;
	logic [7:0]    wd;
	logic [7:0]    rb;
	logic [AW-1:0] wa;
	logic [AW-1:0] addr;
	logic [AW-1:0] am;
	logic [AW-1:0] a;
	logic [15:0]   lfsr;
	logic [7:0]    mdl [8192];
	logic [7:0]    exp_q [$];
	int            fail_count;
	int            checked;
	// pull-up on the shared data wire
	assign sda = (m_low || oe) ? 1'b0 : 1'b1;
	eesr_read dut_u (.ref_clk_i(clk), .sys_rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(),
		.sda_oe_o(oe), .chip_en_i(chip), .mem_we_i(we), .mem_waddr_i(wa),
		.mem_wdata_i(wd), .busy_o(busy), .addr_o(addr));
	eesr_master m_u (.ref_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low),
		.rd_byte_o(rb), .rd_stb_o(stb));
	////////////////////////////////////////////////////////////////////////
	// clock, checks and closing
	initial clk = 1'b0;
	always #50 clk = ~clk;
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// sequences
	task automatic bd_wr(input logic [AW-1:0] ad);
		lfsr = nxt(lfsr);
		@(negedge clk);
		we = 1'b1;
		wa = ad;
		wd = lfsr[7:0];
		mdl[ad] = lfsr[7:0];
		@(negedge clk);
		we = 1'b0;
	endtask
	task automatic sel(input logic rw);
		logic k;
		m_u.start();
		m_u.wr_byte({eesr_pkg::DEV_TYPE, chip, rw}, k);
		chk("select ack", 16'(k), 16'h0000);
	endtask
	// reset for 20 clocks; outputs must already show their idle values at release
	task automatic do_rst();
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		chk("reset busy", 16'(busy), 16'h0000);
		chk("reset drive", 16'(oe), 16'h0000);
		chk("reset counter", 16'(addr), 16'h0000);
		am = '0;
		repeat (4) @(negedge clk);
	endtask
	task automatic rd_seq(input int n);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(mdl[am]);
			am++;
			m_u.rd_byte(i == n - 1);
		end
		// standby must follow the missing ack itself, not only the stop
		chk("standby", 16'(busy), 16'h0000);
		m_u.stop();
		chk("busy", 16'(busy), 16'h0000);
		chk("counter", 16'(addr), 16'(am));
	endtask
	task automatic rnd(input logic [AW-1:0] ad, input int n);
		logic k;
		sel(1'b0);
		m_u.wr_byte({3'b111, ad[12:8]}, k);
		chk("high ack", 16'(k), 16'h0000);
		m_u.wr_byte(ad[7:0], k);
		chk("low ack", 16'(k), 16'h0000);
		am = ad;
		sel(1'b1);
		rd_seq(n);
	endtask
	// read results taken in order off the queue
	initial forever begin
		@(posedge stb);
		chk("read byte", 16'(rb), 16'(exp_q.pop_front()));
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		end_sim();
	end
	// main sequence
	initial begin
		fail_count = 0;
		checked = 0;
		rst = 1'b1;
		we = 1'b0;
		wa = '0;
		wd = 8'h00;
		m_u.init();
		lfsr = 16'h8425;
		for (int i = 0; i < 8192; i++) mdl[i] = 8'hff;
		lfsr = nxt(lfsr);
		chip = lfsr[2:0];
		do_rst();
		sel(1'b1);
		rd_seq(2);
		lfsr = nxt(lfsr);
		a = {1'b0, lfsr[11:0]};
		for (int i = 0; i < 3; i++) bd_wr(a + AW'(i));
		rnd(a, 3);
		bd_wr(13'h1fff);
		bd_wr(13'h0000);
		rnd(13'h1ffe, 3);
		sel(1'b1);
		rd_seq(1);
		// mid-run reset: counter back to zero, array contents kept
		do_rst();
		sel(1'b1);
		rd_seq(1);
		end_sim();
	end
endmodule // eesr_read_tb_top
bind eesr_read eesr_read_monitor #(.ADDR_W(ADDR_W)) mon_u (.ref_clk_i, .sys_rst_i, .scl_i,
	.sda_i, .sda_o, .sda_oe_o, .busy_o, .addr_o);
